// ---- rtl/wztc_pkg.sv ----
// Package of constants and types for the weigh zero/tare/config block.
package wztc_pkg;
	// Register byte offsets.
	localparam logic [7:0] WZTC_CFG_OFF = 8'h00;
	localparam logic [7:0] WZTC_SER_OFF = 8'h04;
	localparam logic [7:0] WZTC_CMD_OFF = 8'h08;
	localparam logic [7:0] WZTC_STAT_OFF = 8'h0c;
	localparam logic [7:0] WZTC_IRQ_OFF = 8'h10;
	localparam logic [7:0] WZTC_MASK_OFF = 8'h14;
	localparam logic [7:0] WZTC_TARE_OFF = 8'h18;
	localparam logic [7:0] WZTC_ZERO_OFF = 8'h1c;
	localparam logic [7:0] WZTC_OUT_OFF = 8'h20;
	localparam logic [7:0] WZTC_CAP_OFF = 8'h24;
	// Config register fields: filter[3:0] motion[6:4] pwr_zero[8:7]
	// zero_range[10:9] zero_tracking[12:11] svc_res[13] tare_en[14]
	// tare_keep[15] mode[17:16].
	localparam int WZTC_FILT_LSB = 0;
	localparam int WZTC_MOT_LSB = 4;
	localparam int WZTC_PZ_LSB = 7;
	localparam int WZTC_ZR_LSB = 9;
	localparam int WZTC_ZT_LSB = 11;
	localparam int WZTC_SRES_BIT = 13;
	localparam int WZTC_TEN_BIT = 14;
	localparam int WZTC_TKEEP_BIT = 15;
	localparam int WZTC_MODE_LSB = 16;
	localparam logic [17:0] WZTC_CFG_RST = 18'h0c227;
	// Serial register: format[2:0] checksum[3] tool_link[4].
	localparam logic [4:0] WZTC_SER_RST = 5'h0a;
	localparam logic [3:0] WZTC_FILT_MAX = 4'h9;
	localparam logic [23:0] WZTC_CAP_RST = 24'h0f4240;
	// Interrupt bits: stable edge, zero done, tare done, cmd refused.
	localparam int WZTC_NIRQ = 4;
	typedef enum logic [1:0] {
		WZTC_COUNT, WZTC_WEIGH, WZTC_FORCE
	} wztc_mode_type;
	typedef enum logic [2:0] {
		WZTC_FMT_OFF, WZTC_FMT_CONT, WZTC_FMT_POLL,
		WZTC_FMT_MB_HL, WZTC_FMT_MB_LH
	} wztc_fmt_type;
	typedef enum logic [1:0] {
		WZTC_BOOT, WZTC_RUN
	} wztc_state_type;
endpackage : wztc_pkg

// ---- rtl/wztc_core.sv ----
// Weight filter, motion, zero, tracking, tare and port format block.
`timescale 1ns/100ps
module wztc_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter samples, same clock
	input wire logic sample_valid,
	input wire logic signed [23:0] sample,
	// Outputs
	output logic signed [27:0] value_out,
	output logic value_valid,
	output logic stable,
	output logic net_mode,
	output logic [2:0] port_format,
	output logic checksum_on,
	output logic irq
);
	import wztc_pkg::*;

	typedef struct packed {
		logic [17:0] cfg;
		logic [4:0] ser;
		logic [23:0] cap;
		logic signed [23:0] filt;
		logic signed [23:0] prev;
		logic signed [23:0] zero;
		logic signed [23:0] tare;
		logic tare_on;
		logic [WZTC_NIRQ-1:0] ist;
		logic [WZTC_NIRQ-1:0] msk;
		logic stable;
		logic zcmd;
		logic tcmd;
		wztc_state_type st;
		logic ph;
		logic [7:0] addr;
		logic wr;
		logic [31:0] rdata;
		logic signed [27:0] vout;
		logic vval;
		logic [2:0] fmt;
		logic cks;
		logic irq;
	} wztc_regs_type;

	wztc_regs_type r_q, r_d;

	////////////////////////////////////////////////////////////////////////
	// Window of percent of capacity; pct code 1=2%, 2=10/20%, 3=40%.
	function automatic logic [23:0] pct_win(input logic [23:0] cap,
		input logic [1:0] code, input logic pwr);
		logic [31:0] c;
		c = {8'h00, cap};
		unique case (code)
			2'd0: pct_win = 24'h000000;
			2'd1: pct_win = 24'((c * 32'd2) / 32'd100);
			2'd2: pct_win = pwr ? 24'((c * 32'd10) / 32'd100)
				: 24'((c * 32'd20) / 32'd100);
			2'd3: pct_win = 24'((c * 32'd40) / 32'd100);
		endcase
	endfunction : pct_win

	function automatic logic [23:0] absv(input logic signed [23:0] v);
		absv = v[23] ? 24'(-v) : 24'(v);
	endfunction : absv

	// Windows in tenths of e for weigh modes, counts in count mode.
	function automatic logic [23:0] mot_win(input logic [2:0] code,
		input logic cnt);
		logic [23:0] w;
		w = 24'h000000;
		unique case (code)
			3'd1: w = cnt ? 24'h00003c : 24'h000003;
			3'd2: w = cnt ? 24'h000064 : 24'h000005;
			3'd3: w = cnt ? 24'h0000c8 : 24'h00000a;
			3'd4: w = cnt ? 24'h000190 : 24'h000014;
			default: w = 24'h000000;
		endcase
		mot_win = w;
	endfunction : mot_win

	// Tracking windows in tenths of e: 0.5e, 1e and 3e.
	function automatic logic [23:0] zt_win(input logic [1:0] code);
		unique case (code)
			2'd0: zt_win = 24'h000000;
			2'd1: zt_win = 24'h000005;
			2'd2: zt_win = 24'h00000a;
			2'd3: zt_win = 24'h00001e;
		endcase
	endfunction : zt_win

	////////////////////////////////////////////////////////////////////////
	logic cnt_mode;
	logic signed [23:0] gross;
	logic signed [23:0] diff;
	logic [23:0] zr_win;
	logic [WZTC_NIRQ-1:0] ev;
	logic signed [23:0] nz;

	always_comb begin
		r_d = r_q;
		ev = '0;
		nz = r_q.zero;
		cnt_mode = r_q.cfg[WZTC_MODE_LSB +: 2] == WZTC_COUNT;
		gross = r_q.filt - r_q.zero;
		diff = r_q.filt - r_q.prev;
		zr_win = pct_win(r_q.cap, r_q.cfg[WZTC_ZR_LSB +: 2], 1'b0);
		// Bus slave: zero-wait, always OKAY.
		if (r_q.ph && r_q.wr) begin
			unique case (r_q.addr)
				WZTC_CFG_OFF: begin
					r_d.cfg = hwdata[17:0];
					// Clamp filter so settings above 9 cannot be held.
					if (hwdata[3:0] > WZTC_FILT_MAX) begin
						r_d.cfg[WZTC_FILT_LSB +: 4] = WZTC_FILT_MAX;
					end
				end
				WZTC_SER_OFF: r_d.ser = hwdata[4:0];
				WZTC_CMD_OFF: begin
					r_d.zcmd = hwdata[0];
					r_d.tcmd = hwdata[1];
					if (hwdata[2]) begin
						r_d.tare_on = 1'b0;
					end
				end
				WZTC_MASK_OFF: r_d.msk = hwdata[WZTC_NIRQ-1:0];
				WZTC_CAP_OFF: r_d.cap = hwdata[23:0];
				default: ;
			endcase
		end
		r_d.ph = hsel && hready && htrans[1];
		r_d.addr = haddr;
		r_d.wr = hwrite;
		r_d.rdata = 32'h00000000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr)
				WZTC_CFG_OFF: r_d.rdata = {14'h0, r_q.cfg};
				WZTC_SER_OFF: r_d.rdata = {27'h0, r_q.ser};
				WZTC_STAT_OFF: r_d.rdata = {29'h0, r_q.st == WZTC_RUN,
					r_q.tare_on, r_q.stable};
				WZTC_IRQ_OFF: r_d.rdata = {28'h0000000, r_q.ist};
				WZTC_MASK_OFF: r_d.rdata = {28'h0000000, r_q.msk};
				WZTC_TARE_OFF: r_d.rdata = 32'(r_q.tare);
				WZTC_ZERO_OFF: r_d.rdata = 32'(r_q.zero);
				WZTC_OUT_OFF: r_d.rdata = 32'(r_q.vout);
				WZTC_CAP_OFF: r_d.rdata = {8'h00, r_q.cap};
				default: r_d.rdata = 32'h00000000;
			endcase
		end
		// Sample path: recursive filter, shift 0 passes the sample as is.
		if (sample_valid) begin
			r_d.prev = r_q.filt;
			r_d.filt = r_q.filt + ((sample - r_q.filt)
				>>> r_q.cfg[WZTC_FILT_LSB +: 4]);
			// Disabled window means always stable.
			r_d.stable = (r_q.cfg[WZTC_MOT_LSB +: 3] == 3'd0) ||
				(absv(diff) <= mot_win(r_q.cfg[WZTC_MOT_LSB +: 3],
				cnt_mode));
			if (r_d.stable && !r_q.stable) begin
				ev[0] = 1'b1;
			end
		end
		unique case (r_q.st)
			WZTC_BOOT: if (sample_valid) begin
				// First sample decides the power-on zero once.
				if (!cnt_mode && r_q.cfg[WZTC_PZ_LSB +: 2] != 2'd0 &&
					absv(sample) <= pct_win(r_q.cap,
					r_q.cfg[WZTC_PZ_LSB +: 2], 1'b1)) begin
					r_d.zero = sample;
				end
				r_d.filt = sample;
				r_d.prev = sample;
				r_d.tare_on = r_q.tare_on && r_q.cfg[WZTC_TKEEP_BIT] &&
					!cnt_mode;
				r_d.st = WZTC_RUN;
			end
			WZTC_RUN: begin
				if (r_q.zcmd) begin
					r_d.zcmd = 1'b0;
					if (!cnt_mode && r_q.stable && zr_win != 24'h0 &&
						absv(r_q.filt) <= zr_win) begin
						r_d.zero = r_q.filt;
						ev[1] = 1'b1;
					end else begin
						ev[3] = 1'b1;
					end
				end else if (r_q.tcmd) begin
					r_d.tcmd = 1'b0;
					if (r_q.cfg[WZTC_TEN_BIT] && !cnt_mode && r_q.stable &&
						gross > 24'sd0) begin
						r_d.tare = gross;
						r_d.tare_on = 1'b1;
						ev[2] = 1'b1;
					end else begin
						ev[3] = 1'b1;
					end
				end else if (sample_valid && !cnt_mode && r_q.stable &&
					r_q.cfg[WZTC_ZT_LSB +: 2] != 2'd0 &&
					absv(gross) <= zt_win(r_q.cfg[WZTC_ZT_LSB +: 2])) begin
					nz = r_q.filt;
					// Track only while total correction stays in range.
					if (absv(nz) <= zr_win) begin
						r_d.zero = nz;
					end
				end
			end
			default: r_d.st = WZTC_BOOT;
		endcase
		// Output value.
		if (cnt_mode) begin
			r_d.vout = 28'(r_q.filt);
		end else if (r_q.cfg[WZTC_SRES_BIT]) begin
			r_d.vout = 28'((gross - (r_q.tare_on ? r_q.tare : 24'sd0))
				* 28'sd10);
		end else begin
			r_d.vout = 28'(gross - (r_q.tare_on ? r_q.tare : 24'sd0));
		end
		r_d.vval = sample_valid && r_q.st == WZTC_RUN;
		// Tool link forces polled access; saved format comes back after.
		r_d.fmt = r_q.ser[4] ? 3'(WZTC_FMT_POLL) : r_q.ser[2:0];
		r_d.cks = r_q.ser[3] && (r_d.fmt == 3'(WZTC_FMT_POLL) ||
			r_d.fmt == 3'(WZTC_FMT_CONT));
		// Sticky events; set wins over write-one clear.
		if (r_q.ph && r_q.wr && r_q.addr == WZTC_IRQ_OFF) begin
			r_d.ist = r_q.ist & ~hwdata[WZTC_NIRQ-1:0];
		end
		r_d.ist = r_d.ist | ev;
		r_d.irq = |(r_d.ist & r_d.msk);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// Tare register keeps its value across reset (retention).
			r_q <= '{cfg: WZTC_CFG_RST, ser: WZTC_SER_RST, cap: WZTC_CAP_RST,
				st: WZTC_BOOT, tare: r_q.tare, tare_on: r_q.tare_on,
				default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	assign hrdata = r_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign value_out = r_q.vout;
	assign value_valid = r_q.vval;
	assign stable = r_q.stable;
	assign net_mode = r_q.tare_on;
	assign port_format = r_q.fmt;
	assign checksum_on = r_q.cks;
	assign irq = r_q.irq;

	////////////////////////////////////////////////////////////////////////
	zero_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.zcmd && !r_q.stable && r_q.st == WZTC_RUN
		|=> r_q.zero == $past(r_q.zero))
		else $error("zero taken while unstable");
	tare_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.tcmd && !r_q.zcmd && r_q.st == WZTC_RUN &&
		(r_q.filt - r_q.zero <= 24'sd0) |=> r_q.tare == $past(r_q.tare))
		else $error("tare taken with non-positive gross");
	filt_max_a: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.cfg[3:0] <= WZTC_FILT_MAX)
		else $error("filter setting above nine");
	count_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.cfg[17:16] == 2'd0 ##1 r_q.cfg[17:16] == 2'd0
		|-> value_out == 28'($past(r_q.filt)))
		else $error("count mode output not filtered counts");
	cks_fmt_a: assert property (@(posedge clk) disable iff (!rst_n)
		checksum_on |-> port_format inside {3'd1, 3'd2})
		else $error("checksum outside polled or continuous");
	tool_fmt_a: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.ser[4] |=> port_format == 3'd2)
		else $error("tool link did not force polled format");
	irq_lvl_a: assert property (@(posedge clk) disable iff (!rst_n)
		irq == |(r_q.ist & r_q.msk))
		else $error("interrupt level mismatch");
	boot_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.st == WZTC_BOOT && sample_valid && r_q.cfg[8:7] == 2'd0
		|=> r_q.zero == $past(r_q.zero))
		else $error("power-on zero applied while disabled");
endmodule : wztc_core

// ---- testbench/wztc_host.sv ----
// Host model that drives the register bus of the block.
`timescale 1ns/100ps
module wztc_host (
	// Clock
	input wire logic clk,
	// Bus requests
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Bus answers
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// The host rewrites settings and then recalibrates, so writes are
	// single words with no ordering hazard.
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hwdata <= ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
endmodule : wztc_host

// ---- testbench/weigh_zero_tare_config_tb_top.sv ----
// Self-checking testbench of the weigh zero/tare/config block.
`timescale 1ns/100ps
module weigh_zero_tare_config_tb_top;
	import wztc_pkg::*;
	logic clk, rst_n, hsel, hwrite, hready, hresp, sample_valid;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, port_format;
	logic [31:0] hwdata, hrdata, q;
	logic signed [23:0] sample;
	logic signed [27:0] value_out;
	logic value_valid, stable, net_mode, checksum_on, irq;
	int mismatches = 0;
	int tests_run = 0;
	// Weigh mode, filter 0, other fields at their defaults.
	localparam logic [31:0] CFG_W = 32'h1c220;

	wztc_host host (.clk(clk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata));
	wztc_core dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp),
		.sample_valid(sample_valid), .sample(sample),
		.value_out(value_out), .value_valid(value_valid),
		.stable(stable), .net_mode(net_mode),
		.port_format(port_format), .checksum_on(checksum_on), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop;
		if (mismatches == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
		repeat (2) @(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0, q);
	endtask : rd

	// Feeds n samples of one value, one every other cycle.
	task automatic feed(input logic signed [23:0] v, input int n);
		repeat (n) begin
			sample_valid <= 1'b1;
			sample <= v;
			@(posedge clk);
			sample_valid <= 1'b0;
			@(posedge clk);
		end
	endtask : feed

	task automatic t_defaults;
		rd(WZTC_CFG_OFF);
		chk("cfg", {14'h0, WZTC_CFG_RST}, q);
		rd(WZTC_SER_OFF);
		chk("ser", {27'h0, WZTC_SER_RST}, q);
		chk("fmt", 32'h2, {29'h0, port_format});
		chk("csum", 32'h1, {31'h0, checksum_on});
		chk("hresp", 32'h0, {31'h0, hresp});
		rd(8'h40);
		chk("unmapped", 32'h0, q);
		wr(WZTC_CFG_OFF, {14'h0, WZTC_CFG_RST[17:4], 4'hf});
		rd(WZTC_CFG_OFF);
		chk("filt", {14'h0, WZTC_CFG_RST[17:4], 4'h9}, q);
	endtask : t_defaults

	task automatic t_formats;
		for (int f = 0; f < 5; f++) begin
			wr(WZTC_SER_OFF, 32'(f) | 32'h8);
			chk("fmt", 32'(f), {29'h0, port_format});
			chk("csum", {31'h0, (f == 1 || f == 2)},
				{31'h0, checksum_on});
		end
		wr(WZTC_SER_OFF, 32'h11);
		chk("tool", 32'h2, {29'h0, port_format});
		wr(WZTC_SER_OFF, 32'h01);
		chk("fmt", 32'h1, {29'h0, port_format});
	endtask : t_formats

	task automatic t_stable_irq;
		wr(WZTC_CFG_OFF, CFG_W);
		wr(WZTC_MASK_OFF, 32'hf);
		feed(24'sd100, 40);
		chk("stable", 32'h1, {31'h0, stable});
		rd(WZTC_IRQ_OFF);
		chk("irq0", 32'h1, q & 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(WZTC_MASK_OFF, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(WZTC_IRQ_OFF, 32'hf);
		rd(WZTC_IRQ_OFF);
		chk("w1c", 32'h0, q);
	endtask : t_stable_irq

	task automatic t_zero_tare;
		wr(WZTC_CMD_OFF, 32'h1);
		rd(WZTC_IRQ_OFF);
		chk("zero", 32'h2, q & 32'h2);
		feed(24'sd5000, 40);
		wr(WZTC_CMD_OFF, 32'h2);
		chk("tare", 32'h1, {31'h0, net_mode});
		wr(WZTC_CMD_OFF, 32'h4);
		chk("clr", 32'h0, {31'h0, net_mode});
		wr(WZTC_IRQ_OFF, 32'hf);
		for (int i = 0; i < 6; i++) begin
			feed(i[0] ? 24'sd90000 : 24'sd1000, 1);
		end
		chk("motion", 32'h0, {31'h0, stable});
		wr(WZTC_CMD_OFF, 32'h2);
		chk("tare_mv", 32'h0, {31'h0, net_mode});
		rd(WZTC_IRQ_OFF);
		chk("refused", 32'h8, q & 32'h8);
	endtask : t_zero_tare

	// Pulses reset the way a power cycle would; the tare survives it.
	task automatic power_cycle(input logic [31:0] cfg);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wr(WZTC_CFG_OFF, cfg);
	endtask : power_cycle

	task automatic t_power;
		feed(24'sd5000, 4);
		wr(WZTC_CMD_OFF, 32'h2);
		feed(24'sd6000, 1);
		@(posedge clk);
		chk("net", 32'd1000, 32'(value_out));
		wr(WZTC_CFG_OFF, CFG_W | 32'h2000);
		chk("svc_res", 32'd10000, 32'(value_out));
		power_cycle(CFG_W);
		feed(24'sd6000, 1);
		chk("keep", 32'h1, {31'h0, net_mode});
		power_cycle(CFG_W | 32'h80);
		feed(24'sd3000, 1);
		rd(WZTC_ZERO_OFF);
		chk("pwr_zero", 32'd3000, q);
		power_cycle(CFG_W | 32'h80);
		feed(24'sd50000, 1);
		rd(WZTC_ZERO_OFF);
		chk("pwr_far", 32'h0, q);
		power_cycle(CFG_W & 32'h17fff);
		feed(24'sd50000, 1);
		chk("no_keep", 32'h0, {31'h0, net_mode});
		wr(WZTC_CFG_OFF, CFG_W | 32'h1800);
		feed(24'sd25, 4);
		rd(WZTC_ZERO_OFF);
		chk("track", 32'd25, q);
		wr(WZTC_CFG_OFF, (CFG_W | 32'h1800) & 32'h1f9ff);
		feed(24'sd10, 4);
		rd(WZTC_ZERO_OFF);
		chk("track_stop", 32'd25, q);
		wr(WZTC_CFG_OFF, CFG_W & 32'h0ffff);
		sample_valid <= 1'b1;
		sample <= 24'sd777;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(negedge clk);
		chk("valid", 32'h1, {31'h0, value_valid});
		@(negedge clk);
		chk("count", 32'd777, 32'(value_out));
		chk("valid", 32'h0, {31'h0, value_valid});
		@(posedge clk);
	endtask : t_power

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		sample_valid = 1'b0;
		sample = 24'sh0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_defaults();
		t_formats();
		t_stable_irq();
		t_zero_tare();
		t_power();
		report_and_stop();
	end
endmodule : weigh_zero_tare_config_tb_top
